// ### src/wwt_map.vh
// Purpose: Offsets, field positions, reset values and timing counts of the watchdog
// Assumes: Word-aligned Avalon-MM byte addresses, 32-bit data
// Notes: Included by the watchdog top only
`ifndef WWT_MAP_VH
`define WWT_MAP_VH

// Register byte offsets
`define WWT_OFS_CTRL 4'h0
`define WWT_OFS_RSTAT 4'h4
`define WWT_OFS_COUNT 4'h8

// Control register fields
`define WWT_B_FLAG 7
`define WWT_B_IE 6
`define WWT_B_PER3 5
`define WWT_B_CE 4
`define WWT_B_WDE 3
`define WWT_B_PER_HI 2

// Reset status register field
`define WWT_B_RSTF 3

// Reset values
`define WWT_RST_PER 4'h0
`define WWT_RST_WDE 1'b0
`define WWT_RST_IE 1'b0

// Timing
`define WWT_OSC_KHZ 128
`define WWT_CLK_MHZ 100
`define WWT_CE_CYC 3'h4
`define WWT_BASE_CYC 21'h00_0800
`define WWT_PER_MAX 4'h9

`endif

// ### src/wwt_top.v
// Purpose: Watchdog timer with timed unlock, interrupt and system reset modes
// Assumes: Oscillator and fuse arrive from outside the mclk domain
// Notes: Counter runs in mclk domain on synchronised oscillator edges
//
// Behaviour
// - Counter advances once per cycle of the independent 128 kHz oscillator.
// - Restart instruction clears counter; firmware must restart before time-out.
// - Time-out selectable from 16 ms to 8 s by period select field.
// - Interrupt mode requests interrupt on expiry; request also wakes from sleep.
// - System reset mode asserts system reset when counter reaches time-out.
// - Combined mode interrupts first, then later expiry resets the system.
// - Always-on fuse forces reset mode: reset enable one, interrupt enable zero.
// - Reset enable clear and period change accepted only within four cycles.
// - Watchdog stays enabled after its own reset; firmware clears flags.
// - Time-out flag bit 7 sets on time-out when interrupt is configured.
// - Flag clears on vector entry or writing one; writing zero does nothing.
// - Interrupt taken only with global enable, interrupt enable and flag set.
// - Control bits: flag 7, ie 6, period3 5, ce 4, wde 3, period 2..0.
// - Change enable clears itself four core cycles after written to one together with reset enable.
// - Reset enable held set while the supervisor reset flag is set.
// - Codes 0..9 select 2048 doubling to 1048576 cycles; others reserved.
// - Combined mode vector entry clears interrupt enable and flag.
`timescale 1ns/1ns
`include "wwt_map.vh"

module wwt_top
(
   // Clock and reset
   input wire mclk,
   input wire sys_rst,
   // Avalon-MM slave
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   // Oscillator and fuse pins
   input wire osc_clk_in,
   input wire always_on_fuse,
   // Core side
   input wire restart_cmd,
   input wire core_global_ie,
   input wire vector_ack,
   // Outputs
   output reg irq_req_q,
   output reg wake_req_q,
   output reg sys_reset_q
);

   localparam MODE_STOP = 2'b00;
   localparam MODE_IRQ = 2'b01;
   localparam MODE_RST = 2'b10;
   localparam MODE_BOTH = 2'b11;

   reg osc_s1_q;
   reg osc_s2_q;
   reg osc_s3_q;
   reg osc_lvl_q;
   reg fuse_s1_q;
   reg fuse_s2_q;
   reg fuse_s3_q;
   reg fuse_q;
   reg ie_q;
   reg wde_q;
   reg flag_q;
   reg rstf_q;
   reg [3:0] per_q;
   reg [2:0] ce_cnt_q;
   reg [20:0] cnt_q;
   reg [20:0] lim_m1;
   reg act_irq;
   reg act_rst;

   wire osc_agree;
   wire fuse_agree;
   wire tick;
   wire wr_acc;
   wire rd_start;
   wire sel_ctl;
   wire sel_rst;
   wire sel_cnt;
   wire ctl_wr;
   wire rst_wr;
   wire ce_open;
   wire unlock;
   wire wde_eff;
   wire ie_eff;
   wire running;
   wire expire;
   wire irq_exp;
   wire rst_exp;
   wire flag_clr;
   wire flag_next;
   wire [1:0] mode;
   wire [7:0] wd;
   wire [7:0] ctl_view;

   // Three-stage sampling; a level change counts once stages two and three agree
   assign osc_agree = (osc_s2_q == osc_s3_q);
   assign fuse_agree = (fuse_s2_q == fuse_s3_q);
   assign tick = osc_agree & osc_s3_q & ~osc_lvl_q;

   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         osc_s3_q <= 1'b0;
         osc_lvl_q <= 1'b0;
      end
      else
      begin
         osc_s1_q <= osc_clk_in;
         osc_s2_q <= osc_s1_q;
         osc_s3_q <= osc_s2_q;
         if (osc_agree)
            osc_lvl_q <= osc_s3_q;
      end
   end

   // Fuse is a slow level on the same scheme
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         fuse_s1_q <= 1'b0;
         fuse_s2_q <= 1'b0;
         fuse_s3_q <= 1'b0;
         fuse_q <= 1'b0;
      end
      else
      begin
         fuse_s1_q <= always_on_fuse;
         fuse_s2_q <= fuse_s1_q;
         fuse_s3_q <= fuse_s2_q;
         if (fuse_agree)
            fuse_q <= fuse_s3_q;
      end
   end

   // Bus access completes at the edge where waitrequest is sampled low
   assign wr_acc = avs_write & ~avs_waitrequest;
   assign rd_start = avs_read & avs_waitrequest;
   assign sel_ctl = (avs_address == `WWT_OFS_CTRL);
   assign sel_rst = (avs_address == `WWT_OFS_RSTAT);
   assign sel_cnt = (avs_address == `WWT_OFS_COUNT);
   assign wd = avs_writedata[7:0];
   assign ctl_wr = wr_acc & sel_ctl;
   assign rst_wr = wr_acc & sel_rst;
   assign ce_open = (ce_cnt_q != 3'h0);
   assign unlock = wd[`WWT_B_CE] & wd[`WWT_B_WDE];

   // Fuse overrides both stored enables; reset flag overrides the reset enable only
   assign wde_eff = wde_q | rstf_q | fuse_q;
   assign ie_eff = ie_q & ~fuse_q;
   assign mode = {wde_eff, ie_eff};
   assign running = (mode != MODE_STOP);

   // Reserved codes fall back to the longest period rather than stopping
   always @*
   begin
      case (per_q)
         4'h0: lim_m1 = `WWT_BASE_CYC - 21'h00_0001;
         4'h1: lim_m1 = (`WWT_BASE_CYC << 1) - 21'h00_0001;
         4'h2: lim_m1 = (`WWT_BASE_CYC << 2) - 21'h00_0001;
         4'h3: lim_m1 = (`WWT_BASE_CYC << 3) - 21'h00_0001;
         4'h4: lim_m1 = (`WWT_BASE_CYC << 4) - 21'h00_0001;
         4'h5: lim_m1 = (`WWT_BASE_CYC << 5) - 21'h00_0001;
         4'h6: lim_m1 = (`WWT_BASE_CYC << 6) - 21'h00_0001;
         4'h7: lim_m1 = (`WWT_BASE_CYC << 7) - 21'h00_0001;
         4'h8: lim_m1 = (`WWT_BASE_CYC << 8) - 21'h00_0001;
         4'h9: lim_m1 = (`WWT_BASE_CYC << 9) - 21'h00_0001;
         default: lim_m1 = (`WWT_BASE_CYC << `WWT_PER_MAX) - 21'h00_0001;
      endcase
   end

   // Pending flag in combined mode means the interrupt was missed
   always @*
   begin
      act_irq = 1'b0;
      act_rst = 1'b0;
      case (mode)
         MODE_STOP:
         begin
            act_irq = 1'b0;
            act_rst = 1'b0;
         end
         MODE_IRQ:
         begin
            act_irq = 1'b1;
            act_rst = 1'b0;
         end
         MODE_RST:
         begin
            act_irq = 1'b0;
            act_rst = 1'b1;
         end
         MODE_BOTH:
         begin
            act_irq = ~flag_q;
            act_rst = flag_q;
         end
      endcase
   end

   // Compare with >= so a shortened period expires on the next oscillator tick
   assign expire = running & tick & (cnt_q >= lim_m1);
   assign irq_exp = expire & act_irq;
   assign rst_exp = expire & act_rst;
   assign flag_clr = vector_ack | (ctl_wr & wd[`WWT_B_FLAG]);
   assign flag_next = (flag_q & ~flag_clr) | irq_exp;

   assign ctl_view = {flag_q, ie_eff, per_q[3], ce_open, wde_eff, per_q[2:0]};

   // Restart, stop or expiry clears the count
   always @(posedge mclk)
   begin
      if (sys_rst)
         cnt_q <= 21'h00_0000;
      else if (restart_cmd | ~running | expire)
         cnt_q <= 21'h00_0000;
      else if (tick)
         cnt_q <= cnt_q + 21'h00_0001;
   end

   // Unlock window counts down in core cycles
   always @(posedge mclk)
   begin
      if (sys_rst)
         ce_cnt_q <= 3'h0;
      else if (ctl_wr & unlock)
         ce_cnt_q <= `WWT_CE_CYC;
      else if (ce_open)
         ce_cnt_q <= ce_cnt_q - 3'h1;
   end

   // Outside the window the enable can only be set
   always @(posedge mclk)
   begin
      if (sys_rst)
         wde_q <= `WWT_RST_WDE;
      else if (ctl_wr & ce_open & ~wd[`WWT_B_CE])
         wde_q <= wd[`WWT_B_WDE];
      else if (ctl_wr)
         wde_q <= wde_q | wd[`WWT_B_WDE];
   end

   // Period moves only inside the window
   always @(posedge mclk)
   begin
      if (sys_rst)
         per_q <= `WWT_RST_PER;
      else if (ctl_wr & ce_open & ~wd[`WWT_B_CE])
         per_q <= {wd[`WWT_B_PER3], wd[`WWT_B_PER_HI:0]};
   end

   // A control write wins over the vector clear in the same cycle
   always @(posedge mclk)
   begin
      if (sys_rst)
         ie_q <= `WWT_RST_IE;
      else if (ctl_wr)
         ie_q <= wd[`WWT_B_IE];
      else if (vector_ack & wde_eff)
         ie_q <= 1'b0;
   end

   // Hardware set wins over any clear in the same cycle
   always @(posedge mclk)
   begin
      if (sys_rst)
         flag_q <= 1'b0;
      else
         flag_q <= flag_next;
   end

   // Clearing takes a zero written to the flag
   always @(posedge mclk)
   begin
      if (sys_rst)
         rstf_q <= 1'b0;
      else if (rst_exp)
         rstf_q <= 1'b1;
      else if (rst_wr & ~wd[`WWT_B_RSTF])
         rstf_q <= 1'b0;
   end

   // Request only with the global enable
   always @(posedge mclk)
   begin
      if (sys_rst)
         irq_req_q <= 1'b0;
      else
         irq_req_q <= core_global_ie & ie_eff & flag_next;
   end

   // Wake ignores the global enable so sleep can be left
   always @(posedge mclk)
   begin
      if (sys_rst)
         wake_req_q <= 1'b0;
      else
         wake_req_q <= ie_eff & flag_next;
   end

   // One-cycle reset pulse per expiry
   always @(posedge mclk)
   begin
      if (sys_rst)
         sys_reset_q <= 1'b0;
      else
         sys_reset_q <= rst_exp;
   end

   // One wait cycle, then a single ready cycle per request
   always @(posedge mclk)
   begin
      if (sys_rst)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
   end

   // Read data loads in the wait cycle and stands until the next read
   always @(posedge mclk)
   begin
      if (sys_rst)
         avs_readdata <= 32'h0000_0000;
      else if (rd_start)
      begin
         if (sel_ctl)
            avs_readdata <= {24'h00_0000, ctl_view};
         else if (sel_rst)
            avs_readdata <= {28'h000_0000, rstf_q, 3'h0};
         else if (sel_cnt)
            avs_readdata <= {11'h000, cnt_q};
         else
            avs_readdata <= 32'h0000_0000;
      end
   end

endmodule

// ### tb/testbench.sv
// Purpose: Directed bench for the watchdog
// Assumes: Fast oscillator from the core model
// Notes: Bit 4 masked on reads, its window is short
`timescale 1ns/1ns
module testbench;
   reg mclk = 0;
   reg sys_rst = 1;
   reg [3:0] avs_address = 4'h0;
   reg avs_read = 0;
   reg avs_write = 0;
   reg [31:0] avs_writedata = 32'h0000_0000;
   reg always_on_fuse = 0;
   reg restart_cmd = 0;
   reg core_global_ie = 0;
   reg ack_en = 0;
   wire [31:0] avs_readdata;
   wire avs_waitrequest, osc_clk_in, vector_ack, irq_req_q, wake_req_q, sys_reset_q;
   integer n_fail = 0;
   integer checked = 0;
   always #5 mclk = ~mclk;
   wwt_top uut (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .osc_clk_in(osc_clk_in), .always_on_fuse(always_on_fuse), .restart_cmd(restart_cmd),
      .core_global_ie(core_global_ie), .vector_ack(vector_ack), .irq_req_q(irq_req_q),
      .wake_req_q(wake_req_q), .sys_reset_q(sys_reset_q));
   wwt_core_model core (.mclk(mclk), .sys_rst(sys_rst), .irq_req_q(irq_req_q),
      .ack_en(ack_en), .osc_clk_in(osc_clk_in), .vector_ack(vector_ack));
   task conclude;
   begin
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   end
   endtask
   task chk(input string nm, input [7:0] got, input [7:0] exp);
   begin
      checked = checked + 1;
      if (got !== exp)
      begin
         n_fail = n_fail + 1;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   end
   endtask
   // Request held until waitrequest is seen low at an edge
   task xfer(input [3:0] a, input wr_n, input [7:0] d);
   begin
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= {24'h00_0000, d};
      avs_write <= !wr_n;
      avs_read <= wr_n;
      @(posedge mclk);
      while (avs_waitrequest)
         @(posedge mclk);
      avs_write <= 0;
      avs_read <= 0;
   end
   endtask
   task rd(input [3:0] a, input [7:0] exp, input string nm);
   begin
      xfer(a, 1, 8'h00);
      chk(nm, avs_readdata[7:0] & 8'hEF, exp);
   end
   endtask
   initial
   begin
      #900_000;
      n_fail = n_fail + 1;
      conclude;
   end
   initial
   begin
      repeat (4) @(posedge mclk);
      sys_rst <= 0;
      rd(4'h0, 8'h00, "ctrl");
      rd(4'hC, 8'h00, "gap");
      core_global_ie <= 1;
      xfer(4'h0, 0, 8'h40);
      repeat (20000) if (!wake_req_q) @(posedge mclk);
      @(posedge mclk);
      chk("irq", {7'h00, irq_req_q}, 8'h01);
      rd(4'h0, 8'hC0, "flag");
      xfer(4'h0, 0, 8'h40);
      rd(4'h0, 8'hC0, "flag0");
      xfer(4'h0, 0, 8'hC0);
      rd(4'h0, 8'h40, "flag1");
      xfer(4'h0, 0, 8'h48);
      restart_cmd <= 1;
      repeat (17000) @(posedge mclk);
      rd(4'h0, 8'h48, "hold");
      restart_cmd <= 0;
      ack_en <= 1;
      repeat (20000) if (!wake_req_q) @(posedge mclk);
      repeat (20) @(posedge mclk);
      rd(4'h0, 8'h08, "vector");
      repeat (20000) if (!sys_reset_q) @(posedge mclk);
      chk("sysrst", {7'h00, sys_reset_q}, 8'h01);
      rd(4'h4, 8'h08, "rstflag");
      restart_cmd <= 1;
      xfer(4'h0, 0, 8'h18);
      xfer(4'h0, 0, 8'h00);
      restart_cmd <= 0;
      rd(4'h0, 8'h08, "held");
      xfer(4'h4, 0, 8'h00);
      rd(4'h4, 8'h00, "rstclr");
      xfer(4'h0, 0, 8'h18);
      repeat (8) @(posedge mclk);
      xfer(4'h0, 0, 8'h00);
      rd(4'h0, 8'h08, "late");
      xfer(4'h0, 0, 8'h18);
      xfer(4'h0, 0, 8'h00);
      rd(4'h0, 8'h00, "off");
      rd(4'h8, 8'h00, "count");
      always_on_fuse <= 1;
      repeat (10) @(posedge mclk);
      xfer(4'h0, 0, 8'h40);
      rd(4'h0, 8'h08, "fuse");
      conclude;
   end
endmodule

// ### tb/wwt_chk_asserts.sv
// Purpose: Port-level checks of the watchdog
// Assumes: One clock domain, sync reset
// Notes: Bound to every watchdog top
`timescale 1ns/1ns
module wwt_chk
(
   // Clock and reset
   input wire mclk,
   input wire sys_rst,
   // Register bus
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   // Core side
   input wire always_on_fuse,
   input wire restart_cmd,
   input wire core_global_ie,
   input wire vector_ack,
   input wire irq_req_q,
   input wire wake_req_q,
   input wire sys_reset_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_irq_gated: assert property (irq_req_q |-> $past(core_global_ie) && wake_req_q)
      else $error("irq without enables");
   a_reset_pulse: assert property (sys_reset_q |=> !sys_reset_q)
      else $error("reset pulse too long");
   a_bus_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
      else $error("late bus answer");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_gap_read: assert property ($rose(avs_read) && avs_address == 4'hC |=> avs_readdata == 0)
      else $error("gap read not zero");
   a_fuse_mask: assert property ($past(always_on_fuse, 5) && always_on_fuse |-> !wake_req_q)
      else $error("interrupt under fuse");
   a_restart_hold: assert property (restart_cmd[*3] |-> !sys_reset_q && !$rose(wake_req_q))
      else $error("expiry during restart");
   a_vector_clear: assert property (vector_ack && !avs_write |-> ##3 !wake_req_q)
      else $error("flag kept after vector");
   cover property (irq_req_q);
   cover property (sys_reset_q);
   cover property (vector_ack ##3 !wake_req_q);
endmodule
bind wwt_top wwt_chk u_chk (.mclk, .sys_rst, .avs_address, .avs_read, .avs_write,
   .avs_readdata, .avs_waitrequest, .always_on_fuse, .restart_cmd, .core_global_ie,
   .vector_ack, .irq_req_q, .wake_req_q, .sys_reset_q);

// ### tb/wwt_core_model.sv
// Purpose: Core model: watchdog oscillator and vector entry
// Assumes: ack_en set by the bench
// Notes: Oscillator runs free, fast to keep runs short
`timescale 1ns/1ns
module wwt_core_model
(
   // Clock and reset
   input wire mclk,
   input wire sys_rst,
   // Watchdog side
   input wire irq_req_q,
   input wire ack_en,
   output reg osc_clk_in,
   output reg vector_ack
);
   integer w;
   initial
   begin
      osc_clk_in = 0;
      vector_ack = 0;
      w = 0;
   end
   always #40 osc_clk_in = ~osc_clk_in;
   // Vector taken only on a pending request, a few cycles late
   always @(posedge mclk)
   begin
      vector_ack <= !sys_rst && ack_en && irq_req_q && w == 4;
      w <= (irq_req_q && ack_en && w < 4) ? w + 1 : 0;
   end
endmodule
